//--- logic/rtcia_pkg.sv
package rtcia_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_CLOCK_CONFIG = 8'hA1;
   localparam logic [7:0] IDX_FRACTION = 8'hA2;
   localparam logic [7:0] IDX_ONE_HZ = 8'hA3;
   localparam logic [7:0] IDX_SIXTY_S = 8'hA4;
   localparam logic [7:0] IDX_HOUR = 8'hA5;
   localparam logic [7:0] IDX_ALARM_INTERVAL = 8'hA6;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hB0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
   localparam logic [7:0] IDX_NOMINAL_TRIM = 8'hF6;
   localparam logic [7:0] IDX_THERMAL_TRIM = 8'hF7;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Clock configuration fields
   localparam int CFG_MIDNIGHT = 7;
   localparam int CFG_DAY_WRAP = 6;
   localparam int CFG_TICK_HI = 5;
   localparam int CFG_TICK_LO = 4;
   localparam int CFG_ONE_SHOT = 3;
   localparam int CFG_ALARM = 2;
   localparam int CFG_INTERVAL_RUN = 1;
   localparam int CFG_CLOCK_RUN = 0;
   localparam logic [7:0] CFG_RESET = 8'h01;
   // Bits cleared by a watchdog or external reset
   localparam logic [7:0] CFG_SOFT_CLEAR = 8'h3E;

   // Interrupt status and mask fields
   localparam int IRQ_MIDNIGHT = 0;
   localparam int IRQ_ALARM = 1;
   localparam int IRQ_W = 2;

   // Tick base encodings
   localparam logic [1:0] TB_FRACTION = 2'h0;
   localparam logic [1:0] TB_SECOND = 2'h1;
   localparam logic [1:0] TB_MINUTE = 2'h2;
   localparam logic [1:0] TB_HOUR = 2'h3;

   // Crystal and counter figures
   localparam int XTAL_HZ = 32768;
   localparam int TICKS_PER_S = 128;
   localparam logic [9:0] XTAL_DIV = 10'(XTAL_HZ / TICKS_PER_S);
   localparam logic [7:0] FRACTION_MAX = 8'h7F;
   localparam logic [7:0] SIXTY_MAX = 8'h3B;
   localparam logic [7:0] HOUR_MAX_24 = 8'h17;
   localparam logic [7:0] HOUR_MAX_256 = 8'hFF;

   typedef struct packed {
      logic xtal_s1;
      logic xtal_s2;
      logic xtal_s3;
      logic srst_s1;
      logic srst_s2;
      logic [9:0] prescale;
      logic [7:0] fraction;
      logic [7:0] one_hz;
      logic [7:0] sixty_s;
      logic [7:0] hour;
      logic [7:0] cfg;
      logic [7:0] interval;
      logic [7:0] nom_trim;
      logic [7:0] therm_trim;
      logic [7:0] iv_count;
      logic iv_done;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic bg_strobe;
      logic ready;
      logic slverr;
      logic [7:0] rdata;
   } rtcia_state_t;

   localparam rtcia_state_t STATE_RESET = '{
      cfg: CFG_RESET,
      default: '0
   };

endpackage

//--- logic/rtcia_top.sv
`timescale 1ns/1ps
module rtcia_top
   import rtcia_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic xtal_in,
   input wire logic soft_rst_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic bg_strobe
);

   rtcia_state_t q;
   rtcia_state_t d;

   logic xtal_rise;
   logic run;
   logic tick;
   logic frac_wrap;
   logic sec_wrap;
   logic min_wrap;
   logic hour_wrap;
   logic iv_tick;
   logic alarm_evt;
   logic setup;
   logic access;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [7:0] hour_max;
   logic [9:0] divisor;

   // Register index from a byte address, zero when out of range
   function automatic logic [7:0] addr_index(input logic [ADDR_W-1:0] a);
      addr_index = (a[ADDR_W-1:10] == '0) ? a[9:2] : 8'h00;
   endfunction

   function automatic logic reg_hit(input logic [7:0] i);
      case (i)
         IDX_CLOCK_CONFIG, IDX_FRACTION, IDX_ONE_HZ, IDX_SIXTY_S, IDX_HOUR,
         IDX_ALARM_INTERVAL, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_NOMINAL_TRIM,
         IDX_THERMAL_TRIM: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction

   // Divisor of the last tick of each second, corrected by both trims
   function automatic logic [9:0] trimmed_div(input logic [7:0] nom, input logic [7:0] therm);
      logic signed [10:0] sum;
      sum = 11'(signed'(XTAL_DIV)) - 11'(signed'(nom)) - 11'(signed'(therm));
      trimmed_div = (sum < 11'sd1) ? 10'h001 : sum[9:0];
   endfunction

   always_comb begin
      d = q;
      tick = 1'b0;
      iv_tick = 1'b0;
      alarm_evt = 1'b0;
      // Pin synchronisers
      d.xtal_s1 = xtal_in;
      d.xtal_s2 = q.xtal_s1;
      d.xtal_s3 = q.xtal_s2;
      d.srst_s1 = soft_rst_in;
      d.srst_s2 = q.srst_s1;
      xtal_rise = q.xtal_s2 & ~q.xtal_s3;
      run = q.cfg[CFG_CLOCK_RUN];
      divisor = (q.fraction == FRACTION_MAX) ? trimmed_div(q.nom_trim, q.therm_trim) : XTAL_DIV;

      // Prescaler counts crystal edges only, no power-mode gating
      if (run && xtal_rise) begin
         if (q.prescale + 10'h001 >= divisor) begin
            d.prescale = 10'h000;
            tick = 1'b1;
         end else begin
            d.prescale = q.prescale + 10'h001;
         end
      end

      frac_wrap = tick && (q.fraction == FRACTION_MAX);
      sec_wrap = frac_wrap && (q.one_hz == SIXTY_MAX);
      min_wrap = sec_wrap && (q.sixty_s == SIXTY_MAX);
      hour_max = q.cfg[CFG_DAY_WRAP] ? HOUR_MAX_24 : HOUR_MAX_256;
      hour_wrap = min_wrap && (q.hour == hour_max);

      if (tick) begin
         d.fraction = frac_wrap ? 8'h00 : q.fraction + 8'h01;
      end
      if (frac_wrap) begin
         d.one_hz = sec_wrap ? 8'h00 : q.one_hz + 8'h01;
      end
      if (sec_wrap) begin
         d.sixty_s = min_wrap ? 8'h00 : q.sixty_s + 8'h01;
      end
      if (min_wrap) begin
         d.hour = hour_wrap ? 8'h00 : q.hour + 8'h01;
      end

      // Interval tick source
      case (q.cfg[CFG_TICK_HI:CFG_TICK_LO])
         TB_FRACTION: iv_tick = tick;
         TB_SECOND: iv_tick = frac_wrap;
         TB_MINUTE: iv_tick = sec_wrap;
         TB_HOUR: iv_tick = min_wrap;
         default: iv_tick = 1'b0;
      endcase

      if (!(q.cfg[CFG_INTERVAL_RUN] && run)) begin
         d.iv_count = 8'h00;
         d.iv_done = 1'b0;
      end else if (iv_tick && !q.iv_done) begin
         if (q.iv_count + 8'h01 == q.interval) begin
            alarm_evt = 1'b1;
            d.iv_count = 8'h00;
            d.iv_done = q.cfg[CFG_ONE_SHOT];
         end else begin
            d.iv_count = q.iv_count + 8'h01;
         end
      end

      // Background measurement strobe once per second while running
      d.bg_strobe = run && frac_wrap;

      // APB slave, one wait-free access phase answered from registers
      setup = psel && !penable;
      access = psel && penable && q.ready;
      idx = addr_index(paddr);
      wbyte = pwdata[7:0];
      wr = access && pwrite && pstrb[0] && reg_hit(idx);
      d.ready = setup;
      d.slverr = setup && !reg_hit(idx);
      d.rdata = 8'h00;
      if (setup && !pwrite) begin
         case (idx)
            IDX_CLOCK_CONFIG: d.rdata = q.cfg;
            IDX_FRACTION: d.rdata = q.fraction;
            IDX_ONE_HZ: d.rdata = q.one_hz;
            IDX_SIXTY_S: d.rdata = q.sixty_s;
            IDX_HOUR: d.rdata = q.hour;
            IDX_ALARM_INTERVAL: d.rdata = q.interval;
            IDX_IRQ_STATUS: d.rdata = {6'h00, q.irq_status};
            IDX_IRQ_MASK: d.rdata = {6'h00, q.irq_mask};
            IDX_NOMINAL_TRIM: d.rdata = q.nom_trim;
            IDX_THERMAL_TRIM: d.rdata = q.therm_trim;
            default: d.rdata = 8'h00;
         endcase
      end

      if (wr) begin
         case (idx)
            IDX_CLOCK_CONFIG: begin
               d.cfg[CFG_DAY_WRAP:CFG_ONE_SHOT] = wbyte[CFG_DAY_WRAP:CFG_ONE_SHOT];
               d.cfg[CFG_INTERVAL_RUN] = wbyte[CFG_INTERVAL_RUN];
               d.cfg[CFG_CLOCK_RUN] = wbyte[CFG_CLOCK_RUN];
               // Flags are cleared by writing zero, a one leaves them
               d.cfg[CFG_MIDNIGHT] = q.cfg[CFG_MIDNIGHT] & wbyte[CFG_MIDNIGHT];
               d.cfg[CFG_ALARM] = q.cfg[CFG_ALARM] & wbyte[CFG_ALARM];
            end
            IDX_FRACTION: d.fraction = wbyte;
            IDX_ONE_HZ: d.one_hz = wbyte;
            IDX_SIXTY_S: d.sixty_s = wbyte;
            IDX_HOUR: d.hour = wbyte;
            IDX_ALARM_INTERVAL: d.interval = wbyte;
            IDX_IRQ_STATUS: d.irq_status = q.irq_status & ~wbyte[IRQ_W-1:0];
            IDX_IRQ_MASK: d.irq_mask = wbyte[IRQ_W-1:0];
            IDX_NOMINAL_TRIM: d.nom_trim = wbyte;
            IDX_THERMAL_TRIM: d.therm_trim = wbyte;
            default: d.irq_mask = q.irq_mask;
         endcase
      end

      // Stopped clock holds every time register at zero
      if (!run) begin
         d.prescale = 10'h000;
         d.fraction = 8'h00;
         d.one_hz = 8'h00;
         d.sixty_s = 8'h00;
         d.hour = 8'h00;
      end

      // Watchdog or external reset leaves time counters, trims, day wrap and run
      if (q.srst_s2) begin
         d.cfg = q.cfg & ~CFG_SOFT_CLEAR;
         d.interval = 8'h00;
         d.iv_count = 8'h00;
         d.iv_done = 1'b0;
         d.irq_status = '0;
         d.irq_mask = '0;
      end

      // Events win over a clear in the same cycle
      if (hour_wrap) begin
         d.cfg[CFG_MIDNIGHT] = 1'b1;
         d.irq_status[IRQ_MIDNIGHT] = 1'b1;
      end
      if (alarm_evt) begin
         d.cfg[CFG_ALARM] = 1'b1;
         d.irq_status[IRQ_ALARM] = 1'b1;
      end

      d.irq = |(q.irq_status & q.irq_mask);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   assign prdata = {24'h000000, q.rdata};
   assign pready = q.ready;
   assign pslverr = q.slverr;
   assign irq = q.irq;
   assign bg_strobe = q.bg_strobe;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_stop_clears: assert property (!q.cfg[CFG_CLOCK_RUN] && !q.srst_s2 |=>
      q.fraction == 8'h00 && q.one_hz == 8'h00 && q.sixty_s == 8'h00 && q.hour == 8'h00 && q.iv_count == 8'h00
      && !bg_strobe)
      else $error("stopped clock left a counter nonzero");

   a_fraction_wrap: assert property (tick && q.fraction == FRACTION_MAX && q.one_hz < SIXTY_MAX && !wr
      |=> q.fraction == 8'h00 && q.one_hz == $past(q.one_hz) + 8'h01)
      else $error("fraction wrap did not carry into seconds");

   a_sixty_wrap: assert property (sec_wrap && q.sixty_s < SIXTY_MAX && !wr
      |=> q.one_hz == 8'h00 && q.sixty_s == $past(q.sixty_s) + 8'h01)
      else $error("seconds wrap did not carry into minutes");

   a_hour_day: assert property (min_wrap && q.cfg[CFG_DAY_WRAP] && q.hour == HOUR_MAX_24 && !wr
      |=> q.hour == 8'h00 && q.cfg[CFG_MIDNIGHT])
      else $error("day mode hour did not wrap at 23");

   a_hour_long: assert property (min_wrap && !q.cfg[CFG_DAY_WRAP] && q.hour == HOUR_MAX_24 && !wr
      |=> q.hour == 8'h18)
      else $error("long mode hour wrapped early");

   a_midnight_irq: assert property (hour_wrap |=> q.cfg[CFG_MIDNIGHT] && q.irq_status[IRQ_MIDNIGHT]
      ##1 (irq == $past(q.irq_mask[IRQ_MIDNIGHT]) || $past(q.irq_mask[IRQ_ALARM] && q.irq_status[IRQ_ALARM])))
      else $error("midnight event lost or interrupt wrong");

   a_interval_hold: assert property (!q.cfg[CFG_INTERVAL_RUN] |=> q.iv_count == 8'h00 && !q.iv_done)
      else $error("stopped interval counter not at zero");

   a_alarm_match: assert property (q.cfg[CFG_INTERVAL_RUN] && run && iv_tick && !q.iv_done && !q.srst_s2
      && q.iv_count + 8'h01 == q.interval |=> q.cfg[CFG_ALARM] && q.irq_status[IRQ_ALARM]
      && q.iv_count == 8'h00 && q.iv_done == $past(q.cfg[CFG_ONE_SHOT]))
      else $error("interval match did not raise alarm");

   a_one_shot_idle: assert property (q.iv_done && q.cfg[CFG_INTERVAL_RUN] && !q.srst_s2 |=> q.iv_count == 8'h00)
      else $error("one-shot timer kept counting");

   a_soft_keeps: assert property (q.srst_s2 && !tick && !wr |=> q.hour == $past(q.hour)
      && q.cfg[CFG_DAY_WRAP] == $past(q.cfg[CFG_DAY_WRAP]) && q.cfg[CFG_CLOCK_RUN] == $past(q.cfg[CFG_CLOCK_RUN]))
      else $error("soft reset disturbed retained state");

   a_tick_spacing: assert property (tick && q.fraction != FRACTION_MAX |-> ##1 !tick [*5])
      else $error("ticks closer than the divider allows");

   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("access phase not answered in one cycle");

   a_irq_level: assert property (##1 irq == $past(|(q.irq_status & q.irq_mask)))
      else $error("interrupt level does not follow status and mask");

   c_midnight: cover property (hour_wrap && q.cfg[CFG_DAY_WRAP]);
   c_alarm_repeat: cover property (alarm_evt && !q.cfg[CFG_ONE_SHOT]);
   c_alarm_once: cover property (alarm_evt && q.cfg[CFG_ONE_SHOT]);
   c_flag_clear_race: cover property (wr && idx == IDX_CLOCK_CONFIG && alarm_evt);

endmodule

//--- verif/rtcia_top_tb.sv
`timescale 1ns/1ps
module rtcia_top_tb;
   import rtcia_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic xtal_in = 1'b0;
   logic soft_rst_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, irq, bg_strobe;
   logic xtal_on = 1'b0;
   logic [31:0] rv;
   logic err, got;
   logic [7:0] cfg;
   int bad_count = 0;
   int tests_run = 0;
   int bg_n = 0;
   int waited = 0;
   int seed = 74;
   int hp = 3;
   int b;
   logic [7:0] regs [7] = '{IDX_FRACTION, IDX_ONE_HZ, IDX_SIXTY_S, IDX_HOUR, IDX_ALARM_INTERVAL,
                            IDX_NOMINAL_TRIM, IDX_THERMAL_TRIM};
   int lim [7] = '{128, 60, 60, 24, 256, 256, 256};

   rtcia_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .xtal_in(xtal_in), .soft_rst_in(soft_rst_in),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .bg_strobe(bg_strobe));

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (bg_strobe === 1'b1) bg_n++;
   // Crystal stands still between scenarios so presets are not disturbed
   always begin
      repeat (hp) @(posedge sys_clk);
      if (xtal_on) xtal_in <= ~xtal_in;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic w(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(nm, rv, {24'h0, e});
   endtask

   task automatic run_wait(input int lim_c);
      int n;
      n = 0;
      got = 1'b0;
      xtal_on <= 1'b1;
      while (n < lim_c && !got) begin
         @(posedge sys_clk);
         n++;
         got = (irq === 1'b1);
      end
      waited = n;
      xtal_on <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // Stop clears the prescaler, then time is preset with the crystal held
   task automatic prep(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s, input logic [7:0] m,
                       input logic [7:0] h);
      w(IDX_CLOCK_CONFIG, 8'h00);
      w(IDX_CLOCK_CONFIG, c);
      w(IDX_IRQ_STATUS, 8'h03);
      w(IDX_FRACTION, f);
      w(IDX_ONE_HZ, s);
      w(IDX_SIXTY_S, m);
      w(IDX_HOUR, h);
   endtask

   task automatic wrap_up;
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      bad_count++;
      wrap_up();
   end

   initial begin
      hp = 3 + {$random(seed)} % 3;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rc("cfg_reset", IDX_CLOCK_CONFIG, CFG_RESET);
      for (int i = 0; i < 7; i++) rc("reg_reset", regs[i], 8'h00);
      bus(1'b0, 8'hA0, 8'h00);
      chk("unmapped_err", 32'(err), 32'h1);
      chk("unmapped_data", rv, 32'h0);
      for (int i = 0; i < 7; i++) begin
         cfg = 8'({$random(seed)} % lim[i]);
         w(regs[i], cfg);
         rc("reg_rw", regs[i], cfg);
      end
      // Write with the low byte strobe off must leave the register alone
      pstrb <= 4'hE;
      w(IDX_THERMAL_TRIM, ~cfg);
      pstrb <= 4'hF;
      rc("strobe_ignore", IDX_THERMAL_TRIM, cfg);
      w(IDX_CLOCK_CONFIG, 8'h4B);
      w(IDX_IRQ_MASK, 8'h03);
      w(IDX_ALARM_INTERVAL, 8'h11);
      w(IDX_HOUR, 8'h05);
      soft_rst_in <= 1'b1;
      repeat (5) @(posedge sys_clk);
      soft_rst_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rc("soft_cfg", IDX_CLOCK_CONFIG, 8'h41);
      rc("soft_hour", IDX_HOUR, 8'h05);
      rc("soft_interval", IDX_ALARM_INTERVAL, 8'h00);
      rc("soft_mask", IDX_IRQ_MASK, 8'h00);
      w(IDX_IRQ_MASK, 8'h03);
      w(IDX_NOMINAL_TRIM, 8'h7F);
      w(IDX_THERMAL_TRIM, 8'h7F);
      for (int m = 0; m < 2; m++) begin
         cfg = m ? 8'h41 : 8'h01;
         prep(cfg, FRACTION_MAX, SIXTY_MAX, SIXTY_MAX, m ? HOUR_MAX_24 : HOUR_MAX_256);
         b = bg_n;
         run_wait(2000);
         chk("midnight_irq", 32'(got), 32'h1);
         chk("trim_short", 32'(waited < 64), 32'h1);
         rc("midnight_cfg", IDX_CLOCK_CONFIG, cfg | 8'h80);
         rc("frac_wrap", IDX_FRACTION, 8'h00);
         rc("sec_wrap", IDX_ONE_HZ, 8'h00);
         rc("min_wrap", IDX_SIXTY_S, 8'h00);
         rc("hour_wrap", IDX_HOUR, 8'h00);
         rc("midnight_status", IDX_IRQ_STATUS, 8'h01);
         chk("strobe_count", 32'(bg_n - b), 32'h1);
         w(IDX_CLOCK_CONFIG, cfg);
         w(IDX_IRQ_STATUS, 8'h01);
         rc("midnight_clear", IDX_CLOCK_CONFIG, cfg);
         chk("irq_clear", 32'(irq), 32'h0);
      end
      for (int tb = 0; tb < 4; tb++) begin
         cfg = 8'h03 | (8'(tb) << 4);
         prep(cfg, tb > 0 ? FRACTION_MAX : 8'h00, tb > 1 ? SIXTY_MAX : 8'h00, tb > 2 ? SIXTY_MAX : 8'h00, 8'h00);
         w(IDX_ALARM_INTERVAL, tb == 0 ? 8'h02 : 8'h01);
         run_wait(8000);
         chk("alarm_irq", 32'(got), 32'h1);
         rc("alarm_cfg", IDX_CLOCK_CONFIG, cfg | 8'h04);
         rc("alarm_status", IDX_IRQ_STATUS, 8'h02);
         if (tb == 0) rc("alarm_ticks", IDX_FRACTION, 8'h02);
      end
      for (int os = 0; os < 2; os++) begin
         cfg = 8'h03 | (8'(os) << 3);
         prep(cfg, 8'h00, 8'h00, 8'h00, 8'h00);
         w(IDX_ALARM_INTERVAL, 8'h01);
         run_wait(4000);
         w(IDX_CLOCK_CONFIG, cfg);
         w(IDX_IRQ_STATUS, 8'h02);
         run_wait(6000);
         chk("alarm_rearm", 32'(got), os ? 32'h0 : 32'h1);
      end
      prep(8'h03, 8'h05, 8'h06, 8'h07, 8'h08);
      w(IDX_CLOCK_CONFIG, 8'h02);
      rc("stop_frac", IDX_FRACTION, 8'h00);
      rc("stop_hour", IDX_HOUR, 8'h00);
      w(IDX_ALARM_INTERVAL, 8'h01);
      b = bg_n;
      run_wait(4000);
      chk("stop_alarm", 32'(got), 32'h0);
      rc("stop_run", IDX_FRACTION, 8'h00);
      chk("stop_strobe", 32'(bg_n - b), 32'h0);
      // Power-on reset in mid-run clears the hour and day wrap that soft resets keep
      w(IDX_CLOCK_CONFIG, 8'h41);
      w(IDX_HOUR, 8'h09);
      rc("por_before", IDX_HOUR, 8'h09);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rc("por_hour", IDX_HOUR, 8'h00);
      rc("por_cfg", IDX_CLOCK_CONFIG, CFG_RESET);
      wrap_up();
   end
endmodule
